// File: cra_pkg.sv
// Purpose: shared constants for the configuration-register message link
// Assumes: tokens are 8-bit values with a control flag, one token per cycle
// Notes: multi-byte fields travel most significant byte first
package cra_pkg;
	localparam logic [7:0] TK_WR = 8'hC0;
	localparam logic [7:0] TK_RD = 8'hC1;
	localparam logic [7:0] TK_PWR = 8'h24;
	localparam logic [7:0] TK_PRD = 8'h25;
	localparam logic [7:0] TK_END = 8'h01;
	localparam logic [7:0] TK_OK = 8'h03;
	localparam logic [7:0] TK_FAIL = 8'h04;
	localparam logic [7:0] PS_SFX = 8'h0C;
	localparam int PS_SHIFT = 8;
	localparam logic [15:0] TILE_SFX = 16'hC20C;
	localparam logic [15:0] NODE_SFX = 16'hC30C;
	localparam logic [7:0] PERI_SFX = 8'h02;
	localparam logic [7:0] PMAX = 8'h04;
	localparam logic [7:0] RID_LAST = 8'h02;
	localparam logic [7:0] CREG_LAST = 8'h01;
	localparam logic [7:0] CDAT_LAST = 8'h03;
	localparam logic [7:0] CFG_LEN = 8'h04;
	typedef enum logic [1:0] {TG_TILE, TG_NODE, TG_PERI} cra_tgt_t;
endpackage

// File: cra_if.sv
// Purpose: token link between a requesting channel end and the register handler
// Assumes: one clock; valid held until ready
// Notes: also carries the processor-status word port
`timescale 1ns/100ps
interface cra_if;
	logic rq_valid;
	logic rq_ctrl;
	logic [7:0] rq_data;
	logic [31:0] rq_dest;
	logic rq_ready;
	logic rs_valid;
	logic rs_ctrl;
	logic [7:0] rs_data;
	logic rs_ready;
	logic ps_req;
	logic ps_wr;
	logic [31:0] ps_rid;
	logic [31:0] ps_wdata;
	logic [31:0] ps_rdata;
	logic ps_ack;
	logic ps_err;
	modport dev (input rq_valid, rq_ctrl, rq_data, rq_dest, rs_ready, ps_req, ps_wr, ps_rid, ps_wdata,
		output rq_ready, rs_valid, rs_ctrl, rs_data, ps_rdata, ps_ack, ps_err);
	modport req (output rq_valid, rq_ctrl, rq_data, rq_dest, rs_ready, ps_req, ps_wr, ps_rid, ps_wdata,
		input rq_ready, rs_valid, rs_ctrl, rs_data, ps_rdata, ps_ack, ps_err);
endinterface

// File: cra_dev.sv
// Purpose: register handler serving configuration and peripheral messages
// Assumes: requester keeps its own framing and destination duties
// Notes: failed messages are drained up to their end token
// Behaviour
// - Status resource id is register shifted, OR 0x0C
// - Status get and set move one word
// - Tile destination is tile id plus suffix
// - Node destination is node id plus c30C
// - Config write: 192, return id, reg, data, 1
// - Config read: 193, return id, reg, 1
// - Peripheral message: 36/37, id, reg, size, data (36 only), 1
// - Write answered 3,1 or 4,1
// - Config read answered 3, word, 1 or 4,1
// - Peripheral read answered 3, data, 1 or 4,1
`timescale 1ns/100ps
module cra_dev import cra_pkg::*; #(
	parameter int NREG = 16,
	parameter int PREG = 64,
	parameter int NPS = 16,
	parameter logic [15:0] NODE_ID = 16'h0001
) (
	// Clock and reset
	input wire logic CLK,
	input wire logic RESETN,
	// Link
	cra_if.dev lk,
	// Status
	output logic BUSY,
	output logic LAST_OK,
	output logic [23:0] LAST_RET
);
	localparam int CW = $clog2(NREG);
	localparam int PW = $clog2(PREG);
	localparam int SW = $clog2(NPS);
	typedef enum {S_IDLE, S_RID, S_REGN, S_SIZE, S_DATA, S_TAIL, S_DRAIN, S_REPLY} cra_dst_t;

	cra_dst_t st_r, st_nxt;
	logic [7:0] cnt_r, cnt_nxt;
	logic wr_r, wr_nxt;
	logic [1:0] tg_r, tg_nxt;
	logic err_r, err_nxt;
	logic [23:0] rid_r, rid_nxt;
	logic [15:0] reg_r, reg_nxt;
	logic [7:0] size_r, size_nxt;
	logic [31:0] wd_r, wd_nxt;
	logic rdy_r, rdy_nxt;
	logic rv_r, rv_nxt;
	logic rc_r, rc_nxt;
	logic [7:0] rd_r, rd_nxt;
	logic busy_r, busy_nxt;
	logic lok_r, lok_nxt;
	logic [23:0] lret_r, lret_nxt;
	logic acc, fin, cm, ok, known;
	logic [7:0] last, len, pidx;
	logic [31:0] cword;
	logic [31:0] cfg_mem [2*NREG];
	logic [7:0] per_mem [PREG];
	logic [31:0] ps_mem [NPS];
	logic pack_r, pack_nxt, perr_r, perr_nxt, ps_ok;
	logic [31:0] prd_r, prd_nxt;

	function automatic logic dest_ok(input logic [31:0] d, input logic [1:0] t);
		dest_ok = (d[31:16] == NODE_ID) &&
			((t == 2'(TG_TILE) && d[15:0] == TILE_SFX) ||
			(t == 2'(TG_NODE) && d[15:0] == NODE_SFX) ||
			(t == 2'(TG_PERI) && d[7:0] == PERI_SFX));
	endfunction

	assign lk.rq_ready = rdy_r;
	assign lk.rs_valid = rv_r;
	assign lk.rs_ctrl = rc_r;
	assign lk.rs_data = rd_r;
	assign lk.ps_ack = pack_r;
	assign lk.ps_err = perr_r;
	assign lk.ps_rdata = prd_r;
	assign BUSY = busy_r;
	assign LAST_OK = lok_r;
	assign LAST_RET = lret_r;

	////////////////////////////////////////////////////////////////////////////////
	// Message parser and reply sequencer
	always_comb begin
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		wr_nxt = wr_r;
		tg_nxt = tg_r;
		err_nxt = err_r;
		rid_nxt = rid_r;
		reg_nxt = reg_r;
		size_nxt = size_r;
		wd_nxt = wd_r;
		rv_nxt = rv_r;
		rc_nxt = rc_r;
		rd_nxt = rd_r;
		lok_nxt = lok_r;
		lret_nxt = lret_r;
		fin = 1'b0;
		cm = 1'b0;
		ok = 1'b0;
		acc = lk.rq_valid && rdy_r;
		known = (lk.rq_data == TK_WR) || (lk.rq_data == TK_RD) || (lk.rq_data == TK_PWR) || (lk.rq_data == TK_PRD);
		len = (tg_r == 2'(TG_PERI)) ? size_r : CFG_LEN;
		last = (!err_r && !wr_r) ? len + 8'h01 : 8'h01;
		pidx = reg_r[7:0] + cnt_r - 8'h01;
		cword = cfg_mem[{tg_r[0], reg_r[CW-1:0]}];
		case (st_r)
			S_IDLE: begin
				if (acc && lk.rq_ctrl) begin
					wr_nxt = (lk.rq_data == TK_WR) || (lk.rq_data == TK_PWR);
					if ((lk.rq_data == TK_PWR) || (lk.rq_data == TK_PRD)) begin
						tg_nxt = 2'(TG_PERI);
					end else begin
						tg_nxt = (lk.rq_dest[15:0] == NODE_SFX) ? 2'(TG_NODE) : 2'(TG_TILE);
					end
					err_nxt = !known || !dest_ok(lk.rq_dest, tg_nxt);
					cnt_nxt = RID_LAST;
					size_nxt = 8'h00;
					wd_nxt = 32'h0000_0000;
					reg_nxt = 16'h0000;
					if (known) begin
						st_nxt = S_RID;
					end else if (lk.rq_data == TK_END) begin
						fin = 1'b1;
					end else begin
						st_nxt = S_DRAIN;
					end
				end
			end
			S_RID, S_REGN, S_SIZE, S_DATA: begin
				if (acc && lk.rq_ctrl) begin
					err_nxt = 1'b1;
					fin = (lk.rq_data == TK_END);
					st_nxt = S_DRAIN;
				end else if (acc) begin
					cnt_nxt = cnt_r - 8'h01;
					case (st_r)
						S_RID: begin
							rid_nxt = {rid_r[15:0], lk.rq_data};
							if (cnt_r == 8'h00) begin
								st_nxt = S_REGN;
								cnt_nxt = (tg_r == 2'(TG_PERI)) ? 8'h00 : CREG_LAST;
							end
						end
						S_REGN: begin
							reg_nxt = {reg_r[7:0], lk.rq_data};
							if (cnt_r == 8'h00) begin
								if (tg_r == 2'(TG_PERI)) begin
									st_nxt = S_SIZE;
								end else begin
									st_nxt = wr_r ? S_DATA : S_TAIL;
									cnt_nxt = CDAT_LAST;
								end
							end
						end
						S_SIZE: begin
							size_nxt = lk.rq_data;
							cnt_nxt = lk.rq_data - 8'h01;
							st_nxt = (wr_r && lk.rq_data != 8'h00) ? S_DATA : S_TAIL;
						end
						default: begin
							wd_nxt = {wd_r[23:0], lk.rq_data};
							if (cnt_r == 8'h00) begin
								st_nxt = S_TAIL;
							end
						end
					endcase
				end
			end
			S_TAIL: begin
				if (acc) begin
					if (lk.rq_ctrl && lk.rq_data == TK_END) begin
						fin = 1'b1;
					end else begin
						err_nxt = 1'b1;
						st_nxt = lk.rq_ctrl ? S_DRAIN : S_TAIL;
					end
				end
			end
			S_DRAIN: begin
				if (acc && lk.rq_ctrl && lk.rq_data == TK_END) begin
					fin = 1'b1;
				end
			end
			S_REPLY: begin
				if (!rv_r || lk.rs_ready) begin
					if (cnt_r > last) begin
						rv_nxt = 1'b0;
						st_nxt = S_IDLE;
						lok_nxt = !err_r;
						lret_nxt = rid_r;
					end else begin
						rv_nxt = 1'b1;
						cnt_nxt = cnt_r + 8'h01;
						if (cnt_r == 8'h00) begin
							rc_nxt = 1'b1;
							rd_nxt = err_r ? TK_FAIL : TK_OK;
						end else if (cnt_r == last) begin
							rc_nxt = 1'b1;
							rd_nxt = TK_END;
						end else if (tg_r == 2'(TG_PERI)) begin
							rc_nxt = 1'b0;
							rd_nxt = per_mem[pidx[PW-1:0]];
						end else begin
							rc_nxt = 1'b0;
							rd_nxt = cword[8*(4-int'(cnt_r))+:8];
						end
					end
				end
			end
			default: st_nxt = S_IDLE;
		endcase
		if (fin) begin
			if (tg_r == 2'(TG_PERI)) begin
				ok = (size_r != 8'h00) && (size_r <= PMAX) && (32'(reg_r[7:0]) + 32'(size_r) <= PREG);
			end else begin
				ok = 32'(reg_r) < NREG;
			end
			ok = ok && !err_nxt;
			err_nxt = !ok;
			cm = ok && wr_r;
			cnt_nxt = 8'h00;
			st_nxt = S_REPLY;
		end
		rdy_nxt = (st_nxt != S_REPLY);
		busy_nxt = (st_nxt != S_IDLE);
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			st_r <= S_IDLE;
			cnt_r <= 8'h00;
			wr_r <= 1'b0;
			tg_r <= 2'(TG_TILE);
			err_r <= 1'b0;
			rid_r <= 24'h000000;
			reg_r <= 16'h0000;
			size_r <= 8'h00;
			wd_r <= 32'h0000_0000;
			rdy_r <= 1'b0;
			rv_r <= 1'b0;
			rc_r <= 1'b0;
			rd_r <= 8'h00;
			busy_r <= 1'b0;
			lok_r <= 1'b0;
			lret_r <= 24'h000000;
			for (int i = 0; i < 2*NREG; i++) begin
				cfg_mem[i] <= 32'h0000_0000;
			end
			for (int i = 0; i < PREG; i++) begin
				per_mem[i] <= 8'h00;
			end
		end else begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			wr_r <= wr_nxt;
			tg_r <= tg_nxt;
			err_r <= err_nxt;
			rid_r <= rid_nxt;
			reg_r <= reg_nxt;
			size_r <= size_nxt;
			wd_r <= wd_nxt;
			rdy_r <= rdy_nxt;
			rv_r <= rv_nxt;
			rc_r <= rc_nxt;
			rd_r <= rd_nxt;
			busy_r <= busy_nxt;
			lok_r <= lok_nxt;
			lret_r <= lret_nxt;
			if (cm && tg_r != 2'(TG_PERI)) begin
				cfg_mem[{tg_r[0], reg_r[CW-1:0]}] <= wd_r;
			end
			if (cm && tg_r == 2'(TG_PERI)) begin
				for (int i = 0; i < int'(PMAX); i++) begin
					if (i < int'(size_r)) begin
						per_mem[PW'(int'(reg_r[7:0]) + i)] <= wd_r[8*(int'(size_r)-1-i)+:8];
					end
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Processor-status word port
	always_comb begin
		ps_ok = (lk.ps_rid[7:0] == PS_SFX) && (lk.ps_rid[31:PS_SHIFT] < NPS);
		pack_nxt = lk.ps_req;
		perr_nxt = lk.ps_req && !ps_ok;
		prd_nxt = prd_r;
		if (lk.ps_req) begin
			prd_nxt = (ps_ok && !lk.ps_wr) ? ps_mem[lk.ps_rid[PS_SHIFT+SW-1:PS_SHIFT]] : 32'h0000_0000;
		end
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			pack_r <= 1'b0;
			perr_r <= 1'b0;
			prd_r <= 32'h0000_0000;
			for (int i = 0; i < NPS; i++) begin
				ps_mem[i] <= 32'h0000_0000;
			end
		end else begin
			pack_r <= pack_nxt;
			perr_r <= perr_nxt;
			prd_r <= prd_nxt;
			if (lk.ps_req && lk.ps_wr && ps_ok) begin
				ps_mem[lk.ps_rid[PS_SHIFT+SW-1:PS_SHIFT]] <= lk.ps_wdata;
			end
		end
	end
endmodule

// File: cra_req.sv
// Purpose: requesting channel end that frames register messages
// Assumes: one command at a time; peripheral data at most four bytes
// Notes: answer collected into RDATA, DONE pulses once per message command
`timescale 1ns/100ps
module cra_req import cra_pkg::*; (
	// Clock and reset
	input wire logic CLK,
	input wire logic RESETN,
	// Link
	cra_if.req lk,
	// Message command
	input wire logic CMD_VALID,
	input wire logic [1:0] CMD_TGT,
	input wire logic CMD_WR,
	input wire logic [15:0] CMD_ID,
	input wire logic [7:0] CMD_PERI,
	input wire logic [15:0] CMD_REG,
	input wire logic [7:0] CMD_SIZE,
	input wire logic [31:0] CMD_WDATA,
	input wire logic [23:0] CMD_RET,
	// Status command
	input wire logic PS_GO,
	input wire logic PS_WRITE,
	input wire logic [23:0] PS_REG,
	input wire logic [31:0] PS_WDATA,
	// Answer
	output logic CMD_READY,
	output logic DONE,
	output logic OK,
	output logic [31:0] RDATA
);
	typedef enum {Q_IDLE, Q_SEND, Q_WAIT} cra_qst_t;

	cra_qst_t st_r, st_nxt;
	logic [7:0] k_r, k_nxt;
	logic [1:0] tg_r, tg_nxt;
	logic wr_r, wr_nxt;
	logic [15:0] reg_r, reg_nxt;
	logic [7:0] sz_r, sz_nxt;
	logic [31:0] wd_r, wd_nxt;
	logic [23:0] ret_r, ret_nxt;
	logic [31:0] dst_r, dst_nxt;
	logic v_r, v_nxt, c_r, c_nxt, rr_r, rr_nxt;
	logic [7:0] d_r, d_nxt;
	logic rdy_r, rdy_nxt, done_r, done_nxt, ok_r, ok_nxt;
	logic [31:0] rdat_r, rdat_nxt;
	logic preq_r, preq_nxt, pwr_r, pwr_nxt;
	logic [31:0] prid_r, prid_nxt, pwd_r, pwd_nxt;
	logic [7:0] last;
	logic [8:0] tk;
	logic per;

	function automatic logic [8:0] token(input logic [7:0] k, input logic p, input logic w, input logic [7:0] lst,
		input logic [23:0] ret, input logic [15:0] rg, input logic [7:0] sz, input logic [31:0] wd);
		int dk;
		dk = int'(k) - (p ? 6 : 6);
		if (k == 8'h00) begin
			token = {1'b1, p ? (w ? TK_PWR : TK_PRD) : (w ? TK_WR : TK_RD)};
		end else if (k == lst) begin
			token = {1'b1, TK_END};
		end else if (k < 8'h04) begin
			token = {1'b0, ret[8*(3-int'(k))+:8]};
		end else if (!p && k < 8'h06) begin
			token = {1'b0, rg[8*(5-int'(k))+:8]};
		end else if (p && k == 8'h04) begin
			token = {1'b0, rg[7:0]};
		end else if (p && k == 8'h05) begin
			token = {1'b0, sz};
		end else if (p) begin
			token = {1'b0, wd[8*int'(2'(int'(sz) - 1 - dk))+:8]};
		end else begin
			token = {1'b0, wd[8*(3-dk)+:8]};
		end
	endfunction

	assign lk.rq_valid = v_r;
	assign lk.rq_ctrl = c_r;
	assign lk.rq_data = d_r;
	assign lk.rq_dest = dst_r;
	assign lk.rs_ready = rr_r;
	assign lk.ps_req = preq_r;
	assign lk.ps_wr = pwr_r;
	assign lk.ps_rid = prid_r;
	assign lk.ps_wdata = pwd_r;
	assign CMD_READY = rdy_r;
	assign DONE = done_r;
	assign OK = ok_r;
	assign RDATA = rdat_r;

	////////////////////////////////////////////////////////////////////////////////
	// Framing, sending and answer collection
	always_comb begin
		st_nxt = st_r;
		k_nxt = k_r;
		tg_nxt = tg_r;
		wr_nxt = wr_r;
		reg_nxt = reg_r;
		sz_nxt = sz_r;
		wd_nxt = wd_r;
		ret_nxt = ret_r;
		dst_nxt = dst_r;
		v_nxt = v_r;
		c_nxt = c_r;
		d_nxt = d_r;
		ok_nxt = ok_r;
		rdat_nxt = rdat_r;
		done_nxt = 1'b0;
		per = (tg_r == 2'(TG_PERI));
		last = per ? (8'h06 + (wr_r ? sz_r : 8'h00)) : (wr_r ? 8'h0A : 8'h06);
		tk = token(k_r, per, wr_r, last, ret_r, reg_r, sz_r, wd_r);
		case (st_r)
			Q_IDLE: begin
				if (CMD_VALID && rdy_r) begin
					tg_nxt = CMD_TGT;
					wr_nxt = CMD_WR;
					reg_nxt = CMD_REG;
					sz_nxt = CMD_SIZE;
					wd_nxt = CMD_WDATA;
					ret_nxt = CMD_RET;
					k_nxt = 8'h00;
					st_nxt = Q_SEND;
					if (CMD_TGT == 2'(TG_PERI)) begin
						dst_nxt = {CMD_ID, CMD_PERI, PERI_SFX};
					end else if (CMD_TGT == 2'(TG_NODE)) begin
						dst_nxt = {CMD_ID, NODE_SFX};
					end else begin
						dst_nxt = {CMD_ID, TILE_SFX};
					end
				end
			end
			Q_SEND: begin
				if (!v_r || lk.rq_ready) begin
					if (k_r > last) begin
						v_nxt = 1'b0;
						st_nxt = Q_WAIT;
						rdat_nxt = 32'h0000_0000;
					end else begin
						v_nxt = 1'b1;
						c_nxt = tk[8];
						d_nxt = tk[7:0];
						k_nxt = k_r + 8'h01;
					end
				end
			end
			Q_WAIT: begin
				if (lk.rs_valid && rr_r) begin
					if (!lk.rs_ctrl) begin
						rdat_nxt = {rdat_r[23:0], lk.rs_data};
					end else if (lk.rs_data == TK_END) begin
						done_nxt = 1'b1;
						st_nxt = Q_IDLE;
					end else begin
						ok_nxt = (lk.rs_data == TK_OK);
					end
				end
			end
			default: st_nxt = Q_IDLE;
		endcase
		rr_nxt = (st_nxt == Q_WAIT);
		rdy_nxt = (st_nxt == Q_IDLE) && !(CMD_VALID && rdy_r);
		preq_nxt = PS_GO;
		pwr_nxt = PS_WRITE;
		prid_nxt = prid_r;
		pwd_nxt = pwd_r;
		if (PS_GO) begin
			prid_nxt = {PS_REG, 8'h00} | {24'h000000, PS_SFX};
			pwd_nxt = PS_WDATA;
		end
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			st_r <= Q_IDLE;
			k_r <= 8'h00;
			tg_r <= 2'(TG_TILE);
			wr_r <= 1'b0;
			reg_r <= 16'h0000;
			sz_r <= 8'h00;
			wd_r <= 32'h0000_0000;
			ret_r <= 24'h000000;
			dst_r <= 32'h0000_0000;
			v_r <= 1'b0;
			c_r <= 1'b0;
			d_r <= 8'h00;
			rr_r <= 1'b0;
			rdy_r <= 1'b0;
			done_r <= 1'b0;
			ok_r <= 1'b0;
			rdat_r <= 32'h0000_0000;
			preq_r <= 1'b0;
			pwr_r <= 1'b0;
			prid_r <= 32'h0000_0000;
			pwd_r <= 32'h0000_0000;
		end else begin
			st_r <= st_nxt;
			k_r <= k_nxt;
			tg_r <= tg_nxt;
			wr_r <= wr_nxt;
			reg_r <= reg_nxt;
			sz_r <= sz_nxt;
			wd_r <= wd_nxt;
			ret_r <= ret_nxt;
			dst_r <= dst_nxt;
			v_r <= v_nxt;
			c_r <= c_nxt;
			d_r <= d_nxt;
			rr_r <= rr_nxt;
			rdy_r <= rdy_nxt;
			done_r <= done_nxt;
			ok_r <= ok_nxt;
			rdat_r <= rdat_nxt;
			preq_r <= preq_nxt;
			pwr_r <= pwr_nxt;
			prid_r <= prid_nxt;
			pwd_r <= pwd_nxt;
		end
	end
endmodule

// File: cra_checker.sv
// Purpose: link checks between requester and handler
// Assumes: one clock, reset active low
// Notes: watches the first link only
`timescale 1ns/100ps
module cra_checker import cra_pkg::*; #(
	parameter int NPS = 16
) (
	// Clock and reset
	input wire logic CLK,
	input wire logic RESETN,
	// Link
	input wire logic rq_valid,
	input wire logic rq_ctrl,
	input wire logic [7:0] rq_data,
	input wire logic rq_ready,
	input wire logic rs_valid,
	input wire logic rs_ctrl,
	input wire logic [7:0] rs_data,
	input wire logic rs_ready,
	input wire logic ps_req,
	input wire logic [31:0] ps_rid,
	input wire logic ps_ack,
	input wire logic ps_err
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RESETN);
	ps_answer_a: assert property (ps_req |=> ps_ack) else $error("status ack missing");
	ps_cause_a: assert property (ps_ack |-> $past(ps_req)) else $error("status ack unasked");
	ps_badid_a: assert property (ps_req && (ps_rid[7:0] != PS_SFX || ps_rid[31:PS_SHIFT] >= NPS)
		|=> ps_err) else $error("bad id not refused");
	reply_open_a: assert property (rs_valid && !$past(rs_valid)
		|-> rs_ctrl && (rs_data == TK_OK || rs_data == TK_FAIL)) else $error("reply opener wrong");
	fail_close_a: assert property (rs_valid && rs_ready && rs_ctrl && rs_data == TK_FAIL
		|-> ##[1:4] (rs_valid && rs_ctrl && rs_data == TK_END)) else $error("fail not closed");
	reply_hold_a: assert property (rs_valid && !rs_ready
		|=> rs_valid && $stable(rs_data) && $stable(rs_ctrl)) else $error("reply token dropped");
	reply_quiet_a: assert property (rs_valid |-> !rq_ready) else $error("ready during reply");
	end_reply_a: assert property (rq_valid && rq_ready && rq_ctrl && rq_data == TK_END
		|-> ##2 rs_valid) else $error("reply late");
	req_hold_a: assert property (rq_valid && !rq_ready
		|=> rq_valid && $stable(rq_data)) else $error("token dropped");
endmodule

// File: testbench.sv
// Purpose: end to end bench for requester and handler
// Assumes: inputs driven at falling edge
// Notes: second link driven raw for malformed messages
`timescale 1ns/100ps
module testbench;
	import cra_pkg::*;
	logic clk, resetn, cv, cw, pg, pw, busy, lok, busy2, lok2, crdy, done, ok;
	logic [1:0] ct;
	logic [15:0] cid, creg;
	logic [7:0] cp, cs;
	logic [31:0] cwd, pwd, rd;
	logic [23:0] cr, preg, lret;
	int failures, checked, cyc;
	cra_if lk();
	cra_if lk2();
	cra_dev cra_dev_i (.CLK(clk), .RESETN(resetn), .lk(lk), .BUSY(busy), .LAST_OK(lok), .LAST_RET(lret));
	cra_dev cra_dev_i2 (.CLK(clk), .RESETN(resetn), .lk(lk2), .BUSY(busy2), .LAST_OK(lok2), .LAST_RET());
	cra_req cra_req_i (.CLK(clk), .RESETN(resetn), .lk(lk), .CMD_VALID(cv), .CMD_TGT(ct), .CMD_WR(cw),
		.CMD_ID(cid), .CMD_PERI(cp), .CMD_REG(creg), .CMD_SIZE(cs), .CMD_WDATA(cwd), .CMD_RET(cr),
		.PS_GO(pg), .PS_WRITE(pw), .PS_REG(preg), .PS_WDATA(pwd), .CMD_READY(crdy), .DONE(done), .OK(ok), .RDATA(rd));
	cra_checker cra_checker_i (.CLK(clk), .RESETN(resetn), .rq_valid(lk.rq_valid), .rq_ctrl(lk.rq_ctrl),
		.rq_data(lk.rq_data), .rq_ready(lk.rq_ready), .rs_valid(lk.rs_valid), .rs_ctrl(lk.rs_ctrl),
		.rs_data(lk.rs_data), .rs_ready(lk.rs_ready), .ps_req(lk.ps_req), .ps_rid(lk.ps_rid),
		.ps_ack(lk.ps_ack), .ps_err(lk.ps_err));
	////////////////////////////////////////////////////////////////
	initial begin
		clk = 0;
		forever #50 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			failures++;
			conclude();
		end
	end
	task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			failures++;
			$display("FAIL %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task conclude();
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	task run_cmd(input logic [1:0] t, input logic w, input logic [15:0] id, input logic [7:0] p,
		input logic [15:0] g, input logic [7:0] s, input logic [31:0] d, input logic xok, input logic [31:0] xrd);
		logic sq, sr;
		sq = 0;
		sr = 0;
		@(negedge clk);
		while (crdy !== 1'b1) @(negedge clk);
		{ct, cw, cid, cp, creg, cs, cwd} = {t, w, id, p, g, s, d};
		cr = cr + 24'h000101;
		cv = 1;
		@(negedge clk);
		cv = 0;
		for (int i = 0; i < 300 && done !== 1'b1; i++) begin
			if (!sq && lk.rq_valid === 1'b1) begin
				sq = 1;
				check("opener", {lk.rq_ctrl, lk.rq_data},
					{1'b1, t == 2 ? (w ? TK_PWR : TK_PRD) : (w ? TK_WR : TK_RD)});
				check("dest", lk.rq_dest, t == 2 ? {id, p, PERI_SFX} : {id, t == 1 ? NODE_SFX : TILE_SFX});
			end
			if (!sr && lk.rs_valid === 1'b1) begin
				sr = 1;
				check("reply tok", {lk.rs_ctrl, lk.rs_data}, {1'b1, xok ? TK_OK : TK_FAIL});
				check("busy", busy, 1'b1);
			end
			@(negedge clk);
		end
		check("done", done, 1'b1);
		@(negedge clk);
		check("ok", ok, xok);
		if (!w && xok) check("rdata", rd, xrd);
		check("last ok", lok, xok);
		check("last ret", lret, cr);
		check("idle", busy, 1'b0);
	endtask
	task ps_op(input logic w, input logic [23:0] g, input logic [31:0] d, input logic xerr, input logic [31:0] xrd);
		@(negedge clk);
		{pw, preg, pwd} = {w, g, d};
		pg = 1;
		@(negedge clk);
		pg = 0;
		for (int i = 0; i < 10 && lk.ps_ack !== 1'b1; i++) begin
			if (lk.ps_req === 1'b1) check("ps rid", lk.ps_rid, {g, PS_SFX});
			@(negedge clk);
		end
		check("ps ack", lk.ps_ack, 1'b1);
		check("ps err", lk.ps_err, xerr);
		if (!w) check("ps rdata", lk.ps_rdata, xrd);
	endtask
	task tok(input logic c, input logic [7:0] d);
		{lk2.rq_valid, lk2.rq_ctrl, lk2.rq_data} = {1'b1, c, d};
		while (lk2.rq_ready !== 1'b1) @(negedge clk);
		@(negedge clk);
	endtask
	task raw_reply();
		logic got;
		got = 0;
		lk2.rq_valid = 0;
		lk2.rq_data = ~lk2.rq_data;
		for (int i = 0; i < 50 && !(got && busy2 === 1'b0); i++) begin
			if (!got && lk2.rs_valid === 1'b1) begin
				got = 1;
				check("raw reply", {lk2.rs_ctrl, lk2.rs_data}, {1'b1, TK_FAIL});
			end
			@(negedge clk);
		end
		check("raw last ok", lok2, 1'b0);
	endtask
	////////////////////////////////////////////////////////////////
	task s_cfg();
		run_cmd(0, 1, 16'h0001, 0, 16'h0003, 0, 32'hA5C3_0F81, 1, 0);
		run_cmd(1, 1, 16'h0001, 0, 16'h0003, 0, 32'h1234_5678, 1, 0);
		run_cmd(0, 0, 16'h0001, 0, 16'h0003, 0, 0, 1, 32'hA5C3_0F81);
		run_cmd(1, 0, 16'h0001, 0, 16'h0003, 0, 0, 1, 32'h1234_5678);
		run_cmd(1, 0, 16'h0001, 0, 16'h000F, 0, 0, 1, 32'h0000_0000);
	endtask
	task s_peri();
		run_cmd(2, 1, 16'h0001, 8'h05, 16'h000A, 8'h04, 32'h1122_3344, 1, 0);
		run_cmd(2, 0, 16'h0001, 8'h05, 16'h000A, 8'h04, 0, 1, 32'h1122_3344);
		run_cmd(2, 0, 16'h0001, 8'h05, 16'h000B, 8'h02, 0, 1, 32'h0000_2233);
		run_cmd(2, 0, 16'h0001, 8'h05, 16'h000D, 8'h01, 0, 1, 32'h0000_0044);
		run_cmd(2, 1, 16'h0001, 8'h05, 16'h003C, 8'h04, 32'hDEAD_BEEF, 1, 0);
	endtask
	task s_fail();
		run_cmd(0, 1, 16'h0001, 0, 16'h0010, 0, 32'hFFFF_FFFF, 0, 0);
		run_cmd(1, 0, 16'h0001, 0, 16'h0010, 0, 0, 0, 0);
		run_cmd(0, 1, 16'h0002, 0, 16'h0003, 0, 32'h0BAD_0BAD, 0, 0);
		run_cmd(2, 0, 16'h0001, 8'h05, 16'h000A, 8'h00, 0, 0, 0);
		run_cmd(2, 1, 16'h0001, 8'h05, 16'h000A, 8'h05, 32'h0102_0304, 0, 0);
		run_cmd(2, 0, 16'h0001, 8'h05, 16'h003E, 8'h04, 0, 0, 0);
		run_cmd(0, 0, 16'h0001, 0, 16'h0003, 0, 0, 1, 32'hA5C3_0F81);
	endtask
	task s_ps();
		ps_op(1, 24'h000005, 32'hCAFE_0005, 0, 0);
		ps_op(1, 24'h00000F, 32'h8000_0001, 0, 0);
		ps_op(0, 24'h000005, 0, 0, 32'hCAFE_0005);
		ps_op(0, 24'h00000F, 0, 0, 32'h8000_0001);
		ps_op(0, 24'h000010, 0, 1, 0);
	endtask
	task s_raw();
		@(negedge clk);
		tok(1, 8'h50);
		tok(1, TK_END);
		raw_reply();
		tok(1, TK_RD);
		tok(0, 8'h01);
		tok(0, 8'h02);
		tok(1, TK_END);
		raw_reply();
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		{resetn, cv, pg, ct, cw, cid, cp, creg, cs, cwd, cr, pw, preg, pwd} = 0;
		{lk2.rq_valid, lk2.rq_ctrl, lk2.rq_data, lk2.ps_req, lk2.ps_wr, lk2.ps_rid, lk2.ps_wdata} = 0;
		lk2.rq_dest = {16'h0001, TILE_SFX};
		lk2.rs_ready = 1;
		failures = 0;
		checked = 0;
		cyc = 0;
		repeat (20) @(negedge clk);
		resetn = 1;
		@(negedge clk);
		s_cfg();
		s_peri();
		s_fail();
		s_ps();
		s_raw();
		conclude();
	end
endmodule
